// *** hdl/tmc_timer16.v ***
// 16-bit timer/counter with mode decode, waveform outputs and input capture
`timescale 1ns/10ps
`default_nettype none
`include "tmc_map.vh"

// What this block does
// - Compare-output codes 10/11 connect that channel's waveform to its pin; 01 only where that channel may toggle.
// - Non-PWM modes: 00 off, 01 toggle, 10 low, 11 high on match.
// - Fast PWM code 01 toggles A only in modes 14/15; B off.
// - Fast PWM 10 clears on match, sets at bottom; 11 inverse.
// - Fast PWM: compare equal to top with upper bit set ignores match.
// - Dual-slope code 01 toggles A only in modes 9/11; B off.
// - Dual-slope 10 clears on up-match, sets on down-match; 11 inverse.
// - Four-bit mode from two bits of control A and two of B.
// - Modes 0-7: normal, phase-correct fixed tops, CTC on A, fast PWM.
// - Modes 8-15: capture or compare A as top; mode 13 runs as normal mode 0.
// - Compare update and overflow timing follow the selected mode.
// - Noise filter changes capture input after four equal samples.
// - Edge select zero captures falling edge, one captures rising edge.
// - Capture copies counter into capture register and sets capture flag.
// - Capture disabled whenever capture register serves as top.
// - Clock select: stop, divide 1/8/64/256/1024, external fall/rise.
module tmc_timer16 (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        capture_in,
	input  wire        ext_clk_in,
	output reg         wave_out_a,
	output reg         wave_conn_a,
	output reg         wave_out_b,
	output reg         wave_conn_b
);

	// ****************************************
	// Control registers
	// ****************************************
	reg  [1:0]  cmp_out_mode_a;
	reg  [1:0]  cmp_out_mode_b;
	reg  [3:0]  wave_mode;
	reg         capture_noise_filter;
	reg         capture_edge_sel;
	reg  [2:0]  clk_sel;
	reg  [15:0] counter_val;
	reg  [15:0] capture_val;
	reg  [15:0] compare_val_a;
	reg  [15:0] compare_val_b;
	reg  [15:0] compare_buf_a;
	reg  [15:0] compare_buf_b;
	reg         overflow_flag;
	reg         cmp_flag_a;
	reg         cmp_flag_b;
	reg         capture_flag;
	reg         count_up;
	reg         block_match;

	// ****************************************
	// Bus decode
	// ****************************************
	wire        access    = psel & penable & pready;
	wire [9:0]  index     = paddr[11:2];
	wire        aligned   = (paddr[1:0] == 2'h0);
	wire        hit_a     = aligned & (index == `TMC_IDX_CTRL_A);
	wire        hit_b     = aligned & (index == `TMC_IDX_CTRL_B);
	wire        hit_cnt   = aligned & (index == `TMC_IDX_COUNTER);
	wire        hit_cap   = aligned & (index == `TMC_IDX_CAPTURE);
	wire        hit_oa    = aligned & (index == `TMC_IDX_COMPARE_A);
	wire        hit_ob    = aligned & (index == `TMC_IDX_COMPARE_B);
	wire        hit_st    = aligned & (index == `TMC_IDX_STATUS);
	wire        mapped    = hit_a | hit_b | hit_cnt | hit_cap | hit_oa | hit_ob | hit_st;
	wire        wr        = access & pwrite & mapped;

	// ****************************************
	// Mode decode
	// ****************************************
	wire m_normal = (wave_mode == 4'd0) | (wave_mode == 4'd13);
	wire m_ctc    = (wave_mode == 4'd4) | (wave_mode == 4'd12);
	wire m_fast   = (wave_mode == 4'd5) | (wave_mode == 4'd6) | (wave_mode == 4'd7) |
	                (wave_mode == 4'd14) | (wave_mode == 4'd15);
	wire m_pfc    = (wave_mode == 4'd8) | (wave_mode == 4'd9);
	wire m_pc     = (wave_mode == 4'd1) | (wave_mode == 4'd2) | (wave_mode == 4'd3) |
	                (wave_mode == 4'd10) | (wave_mode == 4'd11);
	wire m_dual   = m_pfc | m_pc;
	wire top_icr  = (wave_mode == 4'd8) | (wave_mode == 4'd10) |
	                (wave_mode == 4'd12) | (wave_mode == 4'd14);
	wire top_oca  = (wave_mode == 4'd4) | (wave_mode == 4'd9) |
	                (wave_mode == 4'd11) | (wave_mode == 4'd15);
	wire tog_a_ok = m_normal | m_ctc | (m_fast & wave_mode[3]) |
	                (m_dual & wave_mode[0] & wave_mode[3]);

	reg  [15:0] top;
	always @* begin
		case (wave_mode[1:0])
			2'd1:    top = `TMC_TOP_8BIT;
			2'd2:    top = `TMC_TOP_9BIT;
			default: top = `TMC_TOP_10BIT;
		endcase
		if (top_icr) begin
			top = capture_val;
		end else if (top_oca) begin
			top = compare_val_a;
		end else if (m_normal) begin
			top = `TMC_MAX_16;
		end
	end

	// ****************************************
	// Prescaler and external clock
	// ****************************************
	reg  [9:0] prescale;
	reg  [2:0] ext_sync;
	reg        tick;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= 10'h000;
			ext_sync <= 3'h0;
		end else begin
			ext_sync <= {ext_sync[1:0], ext_clk_in};
			// Prescaler runs whenever the clock source is not stopped
			if (clk_sel == `TMC_CS_STOP) begin
				prescale <= 10'h000;
			end else begin
				prescale <= prescale + 10'h001;
			end
		end
	end

	always @* begin
		case (clk_sel)
			`TMC_CS_DIV1:     tick = 1'b1;
			`TMC_CS_DIV8:     tick = (prescale[2:0] == 3'h7);
			`TMC_CS_DIV64:    tick = (prescale[5:0] == 6'h3F);
			`TMC_CS_DIV256:   tick = (prescale[7:0] == 8'hFF);
			`TMC_CS_DIV1024:  tick = (prescale == 10'h3FF);
			`TMC_CS_EXT_FALL: tick = ext_sync[2] & ~ext_sync[1];
			`TMC_CS_EXT_RISE: tick = ~ext_sync[2] & ext_sync[1];
			default:          tick = 1'b0;
		endcase
	end

	// ****************************************
	// Capture input: sync, filter, edge
	// ****************************************
	reg  [1:0] cap_sync;
	reg  [3:0] cap_hist;
	reg        cap_filt;
	reg        cap_prev;
	wire       all_hi   = (cap_hist == 4'hF);
	wire       all_lo   = (cap_hist == 4'h0);
	wire       cap_edge = capture_edge_sel ? (cap_filt & ~cap_prev)
	                                       : (~cap_filt & cap_prev);
	wire       cap_evt  = cap_edge & ~top_icr;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_sync <= 2'h0;
			cap_hist <= 4'h0;
			cap_filt <= 1'b0;
			cap_prev <= 1'b0;
		end else begin
			cap_sync <= {cap_sync[0], capture_in};
			cap_hist <= {cap_hist[2:0], cap_sync[1]};
			cap_prev <= cap_filt;
			// Filter adds latency but rejects glitches shorter than four samples
			if (!capture_noise_filter) begin
				cap_filt <= cap_sync[1];
			end else if (all_hi | all_lo) begin
				cap_filt <= cap_hist[3];
			end
		end
	end

	// ****************************************
	// Counter and events
	// ****************************************
	wire at_top    = (counter_val == top);
	wire at_bottom = (counter_val == 16'h0000);
	wire match_a   = tick & ~block_match & (counter_val == compare_val_a);
	wire match_b   = tick & ~block_match & (counter_val == compare_val_b);
	wire ovf_evt   = tick & (((m_normal | m_ctc) & (counter_val == `TMC_MAX_16)) |
	                 (m_fast & at_top) | (m_dual & at_bottom & ~count_up));
	wire upd_evt   = tick & (((m_fast | m_pc) & at_top) |
	                 (m_pfc & at_bottom & ~count_up));
	wire icf_top   = tick & top_icr & at_top;
	wire buffered  = m_fast | m_dual;

	reg  [15:0] next_counter;
	reg         next_up;
	always @* begin
		next_counter = counter_val;
		next_up      = count_up;
		if (m_dual) begin
			if (count_up & at_top) begin
				next_up      = 1'b0;
				next_counter = counter_val - 16'h0001;
			end else if (!count_up & at_bottom) begin
				next_up      = 1'b1;
				next_counter = counter_val + 16'h0001;
			end else if (count_up) begin
				next_counter = counter_val + 16'h0001;
			end else begin
				next_counter = counter_val - 16'h0001;
			end
		end else if (at_top) begin
			next_up      = 1'b1;
			next_counter = 16'h0000;
		end else begin
			next_up      = 1'b1;
			next_counter = counter_val + 16'h0001;
		end
	end

	// ****************************************
	// Register writes and hardware updates
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_out_mode_a       <= 2'h0;
			cmp_out_mode_b       <= 2'h0;
			wave_mode            <= 4'h0;
			capture_noise_filter <= 1'b0;
			capture_edge_sel     <= 1'b0;
			clk_sel              <= 3'h0;
			counter_val          <= `TMC_RST_WORD;
			capture_val          <= `TMC_RST_WORD;
			compare_val_a        <= `TMC_RST_WORD;
			compare_val_b        <= `TMC_RST_WORD;
			compare_buf_a        <= `TMC_RST_WORD;
			compare_buf_b        <= `TMC_RST_WORD;
			overflow_flag        <= 1'b0;
			cmp_flag_a           <= 1'b0;
			cmp_flag_b           <= 1'b0;
			capture_flag         <= 1'b0;
			count_up             <= 1'b1;
			block_match          <= 1'b0;
		end else begin
			if (wr & hit_a) begin
				cmp_out_mode_a <= pwdata[`TMC_A_COM_A_HI:`TMC_A_COM_A_LO];
				cmp_out_mode_b <= pwdata[`TMC_A_COM_B_HI:`TMC_A_COM_B_LO];
				wave_mode[1:0] <= pwdata[`TMC_A_WM_HI:`TMC_A_WM_LO];
			end
			if (wr & hit_b) begin
				capture_noise_filter <= pwdata[`TMC_B_NOISE];
				capture_edge_sel     <= pwdata[`TMC_B_EDGE];
				wave_mode[3:2]       <= pwdata[`TMC_B_WM_HI:`TMC_B_WM_LO];
				clk_sel              <= pwdata[`TMC_B_CS_HI:`TMC_B_CS_LO];
			end
			if (wr & hit_oa) begin
				compare_buf_a <= pwdata[15:0];
			end
			if (wr & hit_ob) begin
				compare_buf_b <= pwdata[15:0];
			end
			// Buffered modes latch at the update point; the others take the buffer at once
			if (wr & hit_oa & ~buffered) begin
				compare_val_a <= pwdata[15:0];
			end else if (upd_evt | ~buffered) begin
				compare_val_a <= compare_buf_a;
			end
			if (wr & hit_ob & ~buffered) begin
				compare_val_b <= pwdata[15:0];
			end else if (upd_evt | ~buffered) begin
				compare_val_b <= compare_buf_b;
			end
			// A counter write suppresses the match on the next tick
			if (wr & hit_cnt) begin
				counter_val <= pwdata[15:0];
				block_match <= 1'b1;
			end else if (tick) begin
				counter_val <= next_counter;
				count_up    <= next_up;
				block_match <= 1'b0;
			end
			if (cap_evt) begin
				capture_val <= counter_val;
			end else if (wr & hit_cap) begin
				capture_val <= pwdata[15:0];
			end
			// Hardware set wins over a write-one clear in the same cycle
			if (ovf_evt) begin
				overflow_flag <= 1'b1;
			end else if (wr & hit_st & pwdata[`TMC_ST_OVF]) begin
				overflow_flag <= 1'b0;
			end
			if (match_a) begin
				cmp_flag_a <= 1'b1;
			end else if (wr & hit_st & pwdata[`TMC_ST_CMP_A]) begin
				cmp_flag_a <= 1'b0;
			end
			if (match_b) begin
				cmp_flag_b <= 1'b1;
			end else if (wr & hit_st & pwdata[`TMC_ST_CMP_B]) begin
				cmp_flag_b <= 1'b0;
			end
			if (cap_evt | icf_top) begin
				capture_flag <= 1'b1;
			end else if (wr & hit_st & pwdata[`TMC_ST_CAP]) begin
				capture_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// Waveform channels
	// ****************************************
	wire [1:0]  wave_q;
	wire [1:0]  conn_q;
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			wire [1:0]  com   = (ch == 0) ? cmp_out_mode_a : cmp_out_mode_b;
			wire [15:0] ocr   = (ch == 0) ? compare_val_a : compare_val_b;
			wire        match = (ch == 0) ? match_a : match_b;
			wire        tog   = (ch == 0) ? tog_a_ok : (m_normal | m_ctc);
			wire        conn  = (com[1] | (com[0] & tog));
			wire        skip  = m_fast & com[1] & (ocr == top);
			reg         wave;
			reg         next_wave;
			always @* begin
				next_wave = wave;
				if (match & ~skip) begin
					if (com == `TMC_COM_TOGGLE) begin
						next_wave = tog ? ~wave : wave;
					end else if (com[1] & m_dual) begin
						next_wave = count_up ^ com[0];
						next_wave = ~next_wave;
					end else if (com[1]) begin
						next_wave = com[0];
					end
				end
				if (m_fast & com[1] & tick & at_top) begin
					next_wave = ~com[0];
				end
			end
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wave <= 1'b0;
				end else begin
					wave <= next_wave;
				end
			end
			assign wave_q[ch] = wave;
			assign conn_q[ch] = conn;
		end
	endgenerate

	// ****************************************
	// Outputs and bus answer
	// ****************************************
	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h0000_0000;
		if (hit_a) begin
			rd_word[7:0] = {cmp_out_mode_a, cmp_out_mode_b, 2'h0, wave_mode[1:0]};
		end else if (hit_b) begin
			rd_word[7:0] = {capture_noise_filter, capture_edge_sel, 1'b0,
			                wave_mode[3:2], clk_sel};
		end else if (hit_cnt) begin
			rd_word[15:0] = counter_val;
		end else if (hit_cap) begin
			rd_word[15:0] = capture_val;
		end else if (hit_oa) begin
			rd_word[15:0] = compare_buf_a;
		end else if (hit_ob) begin
			rd_word[15:0] = compare_buf_b;
		end else if (hit_st) begin
			rd_word[3:0] = {capture_flag, cmp_flag_b, cmp_flag_a, overflow_flag};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			wave_out_a  <= 1'b0;
			wave_conn_a <= 1'b0;
			wave_out_b  <= 1'b0;
			wave_conn_b <= 1'b0;
		end else begin
			// One wait state: ready rises on the second access cycle
			pready      <= psel & penable & ~pready;
			pslverr     <= psel & penable & ~pready & ~mapped;
			prdata      <= (psel & penable & ~pready & ~pwrite) ? rd_word : 32'h0000_0000;
			wave_out_a  <= wave_q[0];
			wave_conn_a <= conn_q[0];
			wave_out_b  <= wave_q[1];
			wave_conn_b <= conn_q[1];
		end
	end

endmodule // tmc_timer16
`default_nettype wire

// *** shared/tmc_map.vh ***
// Register map, field positions, reset values and mode codes of the 16-bit timer block
`ifndef TMC_MAP_VH
`define TMC_MAP_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define TMC_IDX_CTRL_A      10'h080
`define TMC_IDX_CTRL_B      10'h081
`define TMC_IDX_COUNTER     10'h084
`define TMC_IDX_CAPTURE     10'h086
`define TMC_IDX_COMPARE_A   10'h088
`define TMC_IDX_COMPARE_B   10'h08A
`define TMC_IDX_STATUS      10'h090

// ****************************************
// Field positions
// ****************************************
`define TMC_A_COM_A_HI      7
`define TMC_A_COM_A_LO      6
`define TMC_A_COM_B_HI      5
`define TMC_A_COM_B_LO      4
`define TMC_A_WM_HI         1
`define TMC_A_WM_LO         0
`define TMC_B_NOISE         7
`define TMC_B_EDGE          6
`define TMC_B_WM_HI         4
`define TMC_B_WM_LO         3
`define TMC_B_CS_HI         2
`define TMC_B_CS_LO         0
`define TMC_ST_OVF          0
`define TMC_ST_CMP_A        1
`define TMC_ST_CMP_B        2
`define TMC_ST_CAP          3

// ****************************************
// Reset values
// ****************************************
`define TMC_RST_CTRL        8'h00
`define TMC_RST_WORD        16'h0000

// ****************************************
// Fixed maxima and timing
// ****************************************
`define TMC_MAX_16          16'hFFFF
`define TMC_TOP_8BIT        16'h00FF
`define TMC_TOP_9BIT        16'h01FF
`define TMC_TOP_10BIT       16'h03FF
`define TMC_FILTER_SAMPLES  4

// ****************************************
// Clock select codes
// ****************************************
`define TMC_CS_STOP         3'h0
`define TMC_CS_DIV1         3'h1
`define TMC_CS_DIV8         3'h2
`define TMC_CS_DIV64        3'h3
`define TMC_CS_DIV256       3'h4
`define TMC_CS_DIV1024      3'h5
`define TMC_CS_EXT_FALL     3'h6
`define TMC_CS_EXT_RISE     3'h7

// ****************************************
// Compare output codes
// ****************************************
`define TMC_COM_OFF         2'h0
`define TMC_COM_TOGGLE      2'h1
`define TMC_COM_CLEAR       2'h2
`define TMC_COM_SET         2'h3

`endif

// *** test/testbench.sv ***
// Self-checking bench for the timer block: bus tasks and mode scenarios
`timescale 1ns/10ps
`default_nettype none
`include "tmc_map.vh"
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rdat, c0, st;
	logic        rerr, cap_level = 0, ext_run = 0, dir_a = 1;
	logic [15:0] dd;
	wire  [31:0] prdata;
	wire         pready, pslverr, capture_in, ext_clk_in, pin_a, pin_b;
	wire         wave_out_a, wave_conn_a, wave_out_b, wave_conn_b;
	int          num_errors = 0, comparisons = 0, cyc = 0, h, el, t0, k, m, cd;
	int          cmpv[12] = '{9, 9, 9, 5, 5, 5, 19, 19, 5, 5, 5, 9};
	int          ctb[12] = '{8'h09, 8'h09, 8'h09, 8'h19, 8'h19, 8'h19, 8'h19, 8'h19,
	                         8'h11, 8'h11, 8'h11, 8'h11};
	int          cta[12] = '{8'h40, 8'h80, 8'hC0, 8'h42, 8'h82, 8'hC2, 8'h82, 8'hC2,
	                         8'h82, 8'hC2, 8'h80, 8'h41};
	int          per[12] = '{40, 40, 40, 40, 20, 20, 20, 20, 38, 38, 38, 36};
	int          hie[12] = '{20, 0, 40, 20, 6, 14, 20, 0, 10, 28, 10, 18};
	int          cb[7] = '{8'h41, 8'h41, 8'h01, 8'h01, 8'hC1, 8'hC1, 8'h41};
	int          cv[7] = '{1, 0, 1, 0, 1, 1, 1};
	int          cw[7] = '{0, 0, 0, 0, 3, 6, 3};
	int          ce[7] = '{1, 0, 0, 1, 0, 1, 1};
	int          dv[5] = '{1, 8, 64, 256, 1024};
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	tmc_timer16 i_tmc_timer16 (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_in(capture_in), .ext_clk_in(ext_clk_in),
		.wave_out_a(wave_out_a), .wave_conn_a(wave_conn_a), .wave_out_b(wave_out_b),
		.wave_conn_b(wave_conn_b));
	tmc_pin_model i_tmc_pin_model (.pclk(pclk), .presetn(presetn), .cap_level(cap_level),
		.ext_run(ext_run), .dir_a(dir_a), .dir_b(1'b1), .wave_out_a(wave_out_a),
		.wave_conn_a(wave_conn_a), .wave_out_b(wave_out_b), .wave_conn_b(wave_conn_b),
		.capture_in(capture_in), .ext_clk_in(ext_clk_in), .pin_a(pin_a), .pin_b(pin_b));
	task wrap_up;
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// Request held until pready is sampled high
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			wrap_up();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wr(input logic [9:0] i, input logic [31:0] d);
		bus(1'b1, {i, 2'h0}, d);
	endtask
	task rd(input logic [9:0] i);
		bus(1'b0, {i, 2'h0}, 32'h0);
	endtask
	// Pin step or pulse, then status sampled and flags cleared
	task capt(input logic v, input int w);
		cap_level <= v;
		if (w > 0) begin
			repeat (w) @(posedge pclk);
			cap_level <= ~v;
		end
		repeat (14) @(posedge pclk);
		rd(`TMC_IDX_STATUS);
		st = rdat;
		wr(`TMC_IDX_STATUS, 32'hF);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TMC_IDX_CTRL_A); check(rdat, 32'h0);
		rd(`TMC_IDX_CTRL_B); check(rdat, 32'h0);
		wr(`TMC_IDX_CTRL_A, 32'hFFFFFFFF); rd(`TMC_IDX_CTRL_A); check(rdat, 32'hF3);
		wr(`TMC_IDX_CTRL_B, 32'hFFFFFFFF); rd(`TMC_IDX_CTRL_B); check(rdat, 32'hDF);
		rd(10'h3FF); check({rerr, rdat[30:0]}, 32'h80000000);
		bus(1'b1, 12'h201, 32'h0); check(rerr, 1'b1);
		// Connection across every mode and output code, counter stopped
		for (cd = 0; cd < 4; cd++)
			for (m = 0; m < 16; m++) begin
				wr(`TMC_IDX_CTRL_A, {cd[1:0], cd[1:0], 2'h0, m[1:0]});
				wr(`TMC_IDX_CTRL_B, {m[3:2], 3'h0});
				repeat (3) @(posedge pclk);
				check(wave_conn_a, cd > 1 ||
					(cd == 1 && m inside {0, 4, 9, 11, 12, 13, 14, 15}));
				check(wave_conn_b, cd > 1 ||
					(cd == 1 && m inside {0, 4, 12, 13}));
			end
		wr(`TMC_IDX_CAPTURE, 32'd19);
		for (k = 0; k < 12; k++) begin
			wr(`TMC_IDX_COMPARE_A, cmpv[k]); wr(`TMC_IDX_CTRL_B, ctb[k]); wr(`TMC_IDX_CTRL_A, cta[k]);
			// Restart from bottom so a shrunken top cannot strand the counter above it
			wr(`TMC_IDX_COUNTER, 32'h0);
			repeat (60) @(posedge pclk);
			h = 0;
			repeat (per[k]) begin
				@(posedge pclk);
				if (pin_a === 1'b1) h++;
			end
			check(h, hie[k]);
		end
		wr(`TMC_IDX_CTRL_B, 32'h09); wr(`TMC_IDX_CTRL_A, 32'h80);
		wr(`TMC_IDX_COUNTER, 32'h0);
		repeat (30) @(posedge pclk);
		check(pin_a, 1'b0);
		dir_a <= 1'b0;
		repeat (2) @(posedge pclk);
		check(pin_a, 1'b1);
		dir_a <= 1'b1;
		// Channel B in set-on-match then clear-on-match mode, each checked after its own match
		wr(`TMC_IDX_COMPARE_B, 32'd3); wr(`TMC_IDX_CTRL_A, 32'hB0);
		repeat (20) @(posedge pclk);
		check(pin_b, 1'b1);
		wr(`TMC_IDX_CTRL_A, 32'hA0);
		repeat (20) @(posedge pclk);
		check(pin_b, 1'b0);
		// Capture edges and filter, normal mode at full rate
		wr(`TMC_IDX_CTRL_A, 32'h0); wr(`TMC_IDX_STATUS, 32'hF);
		wr(`TMC_IDX_CTRL_B, cb[0]); rd(`TMC_IDX_COUNTER); c0 = rdat;
		for (k = 0; k < 7; k++) begin
			wr(`TMC_IDX_CTRL_B, cb[k]); capt(cv[k][0], cw[k]);
			check(st[3], ce[k]);
			if (k == 0) begin
				rd(`TMC_IDX_CAPTURE); dd = rdat[15:0] - c0[15:0];
				check(dd > 0 && dd < 40, 1'b1);
			end
		end
		wr(`TMC_IDX_CAPTURE, 32'd19); wr(`TMC_IDX_CTRL_B, 32'h59); wr(`TMC_IDX_CTRL_A, 32'h02);
		capt(1'b1, 3); rd(`TMC_IDX_CAPTURE); check(rdat, 32'd19);
		// Clock select: stopped, prescaled, external
		wr(`TMC_IDX_CTRL_A, 32'h0); wr(`TMC_IDX_CTRL_B, 32'h0);
		rd(`TMC_IDX_COUNTER); c0 = rdat;
		repeat (20) @(posedge pclk);
		rd(`TMC_IDX_COUNTER); check(rdat, c0);
		for (k = 1; k < 8; k++) begin
			wr(`TMC_IDX_CTRL_B, k); rd(`TMC_IDX_COUNTER); c0 = rdat; t0 = cyc;
			if (k > 5) begin
				ext_run <= 1'b1;
				repeat (80) @(posedge pclk);
				ext_run <= 1'b0;
				repeat (10) @(posedge pclk);
			end else
				repeat (16 * dv[k - 1]) @(posedge pclk);
			rd(`TMC_IDX_COUNTER); el = cyc - t0; dd = rdat[15:0] - c0[15:0];
			if (k > 5)
				check(dd, 16'd10);
			else
				check(dd + 1 >= el / dv[k - 1] && dd <= el / dv[k - 1] + 1, 1'b1);
		end
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

// *** test/tmc_pin_model.sv ***
// Pin-side model: capture pin, external count clock and the two waveform pins
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic cap_level,
	input  wire logic ext_run,
	input  wire logic dir_a,
	input  wire logic dir_b,
	input  wire logic wave_out_a,
	input  wire logic wave_conn_a,
	input  wire logic wave_out_b,
	input  wire logic wave_conn_b,
	output var  logic capture_in,
	output var  logic ext_clk_in,
	output var  logic pin_a,
	output var  logic pin_b
);
	logic [1:0] div;
	assign capture_in = cap_level;
	// External clock stands still unless a burst is requested
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 2'h0;
			ext_clk_in <= 1'b0;
		end else if (ext_run) begin
			div <= div + 2'h1;
			if (div == 2'h3)
				ext_clk_in <= ~ext_clk_in;
		end
	end
	// Pull-up holds the pin high while its driver is off
	assign pin_a = !dir_a ? 1'b1 : (wave_conn_a ? wave_out_a : 1'b0);
	assign pin_b = !dir_b ? 1'b1 : (wave_conn_b ? wave_out_b : 1'b0);
endmodule // tmc_pin_model
`default_nettype wire

// *** test/tmc_timer16_asserts.sv ***
// Port-level checker for the timer block
`timescale 1ns/10ps
`default_nettype none
`include "tmc_map.vh"
module tmc_timer16_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        capture_in,
	input wire logic        ext_clk_in,
	input wire logic        wave_out_a,
	input wire logic        wave_conn_a,
	input wire logic        wave_out_b,
	input wire logic        wave_conn_b
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_s;
		psel && penable && pready;
	endsequence
	sequence wr_a_s;
		acc_s ##0 (pwrite && paddr == {`TMC_IDX_CTRL_A, 2'h0});
	endsequence
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	wait_state_a: assert property ($rose(penable) && psel |=> pready)
		else $error("pready not one cycle after access start");
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error response");
	misalign_err_a: assert property (acc_s ##0 (paddr[1:0] != 2'h0) |-> pslverr)
		else $error("misaligned access accepted");
	rsvd_a_zero_a: assert property (acc_s ##0 (!pwrite && paddr == {`TMC_IDX_CTRL_A, 2'h0}) |->
		prdata[31:8] == 24'h0 && prdata[3:2] == 2'h0) else $error("ctrl A reserved bits set");
	rsvd_b_zero_a: assert property (acc_s ##0 (!pwrite && paddr == {`TMC_IDX_CTRL_B, 2'h0}) |->
		prdata[31:8] == 24'h0 && !prdata[5]) else $error("ctrl B reserved bits set");
	conn_on_a: assert property (wr_a_s ##0 pwdata[7] |-> ##[1:2] wave_conn_a)
		else $error("channel A not connected");
	conn_off_a: assert property (wr_a_s ##0 (pwdata[7:6] == 2'h0) |-> ##[1:2] !wave_conn_a)
		else $error("channel A not released");
	conn_b_on_a: assert property (wr_a_s ##0 pwdata[5] |-> ##[1:2] wave_conn_b)
		else $error("channel B not connected");
	conn_b_off_a: assert property (wr_a_s ##0 (pwdata[5:4] == 2'h0) |-> ##[1:2] !wave_conn_b)
		else $error("channel B not released");
	reset_outs_a: assert property ($rose(presetn) |-> !wave_conn_a && !wave_conn_b && !pready)
		else $error("outputs active after reset");
endmodule // tmc_timer16_asserts
bind tmc_timer16 tmc_timer16_asserts i_tmc_timer16_asserts (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_in(capture_in),
	.ext_clk_in(ext_clk_in), .wave_out_a(wave_out_a), .wave_conn_a(wave_conn_a),
	.wave_out_b(wave_out_b), .wave_conn_b(wave_conn_b));
`default_nettype wire
